// *** hw/ced_dispatch.sv ***
`timescale 1ns/1ps
`include "ced_params.svh"

// Behaviour
// - Hardware interrupts taken only at boundaries; return to following instruction.
// - Faults dispatch before execution; return address is the faulting instruction.
// - Traps dispatch after execution; return address is past the instruction.
// - Aborts report severe errors; return address need not be precise.
// - Vector space holds 256 vectors; 0 to 31 architectural, rest free.
// - Table entry is 4 bytes in real mode, 8 bytes in protected.
// - Push program address and flags first, then index table with vector.
// - Return instruction restores saved address and flags, resumes execution.
// - Maskable vector comes from acknowledge sequence; others internal or opcode.
// - Non-maskable request uses vector 2 without acknowledge sequence.
// - Maskable request accepted only with enable flag set, between instructions.
// - Repeated string instructions accept interrupts between memory moves.
// - Entry clears enable flag; software may set it; return restores it.
// - Non-maskable requests blocked during their handler until return or reset.
// - Non-maskable request during handler held pending, served after first return.
// - Non-maskable entry clears the enable flag.
// - Software trap opcode n dispatches vector n as an exception.
// - Breakpoint opcode dispatches vector 3 as a trap.
// - Non-maskable wins over maskable at the same boundary.
// - Page faults dispatch vector 14 as faults.
// - Debug events use vector 1; may report trap and fault together.
// - Boundary order: debug trap, debug fault, external requests, fetch faults.
module ced_dispatch
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic nmi_pin_in,
    input wire logic maskable_request_in,
    input wire logic boundary_in,
    input wire logic string_window_in,
    input wire logic [31:0] current_addr_in,
    input wire logic [31:0] next_addr_in,
    input wire logic [31:0] flags_in,
    input wire logic real_mode_in,
    input wire logic exc_valid_in,
    input wire ced_pkg::ced_cause_t exc_cause_in,
    input wire logic swint_valid_in,
    input wire logic [7:0] swint_vector_in,
    input wire logic breakpoint_in,
    input wire logic dbg_trap_in,
    input wire logic dbg_fault_in,
    input wire logic fetch_fault_in,
    input wire ced_pkg::ced_cause_t fetch_cause_in,
    input wire logic push_done_in,
    input wire logic inta_valid_in,
    input wire logic [7:0] inta_vector_in,
    input wire logic ret_valid_in,
    input wire logic [31:0] ret_flags_in,
    input wire logic set_if_in,
    input wire logic clear_if_in,
    output logic busy_out,
    output logic push_req_out,
    output logic inta_req_out,
    output logic dispatch_valid_out,
    output logic [7:0] vector_out,
    output ced_pkg::ced_kind_t kind_out,
    output logic dbg_both_out,
    output logic arch_vector_out,
    output logic [31:0] return_addr_out,
    output logic [31:0] saved_flags_out,
    output logic [10:0] table_offset_out,
    output logic int_enable_out,
    output logic nmi_blocked_out,
    output logic nmi_pending_out
);
    import ced_pkg::*;

    // ==========================================
    // Cause classification
    function automatic logic [7:0] cause_vec(input ced_cause_t c);
        logic [7:0] v;
        unique case (c)
            CED_C_DIVIDE: v = `CED_VEC_DIVIDE;
            CED_C_BOUNDS: v = `CED_VEC_BOUNDS;
            CED_C_INVALID_OP: v = `CED_VEC_INVALID_OP;
            CED_C_DEV_NA: v = `CED_VEC_DEV_NA;
            CED_C_INVALID_TSS: v = `CED_VEC_INVALID_TSS;
            CED_C_SEG_ABSENT: v = `CED_VEC_SEG_ABSENT;
            CED_C_STACK: v = `CED_VEC_STACK;
            CED_C_PROTECT: v = `CED_VEC_PROTECT;
            CED_C_PAGE: v = `CED_VEC_PAGE;
            CED_C_FLOAT: v = `CED_VEC_FLOAT;
            CED_C_ALIGN: v = `CED_VEC_ALIGN;
            CED_C_OVERFLOW: v = `CED_VEC_OVERFLOW;
            CED_C_DOUBLE: v = `CED_VEC_DOUBLE;
            // Undefined codes escalate rather than vanish
            default: v = `CED_VEC_DOUBLE;
        endcase
        return v;
    endfunction

    function automatic ced_kind_t cause_kind(input ced_cause_t c);
        if (c == CED_C_OVERFLOW)
            return CED_KIND_TRAP;
        if (c >= CED_C_DOUBLE)
            return CED_KIND_ABORT;
        return CED_KIND_FAULT;
    endfunction

    // ==========================================
    // Pin synchronisers
    logic nmi_sync;
    logic maskable_request_sync;

    ced_sync u_nmi_sync
    (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .async_in(nmi_pin_in),
        .sync_out(nmi_sync)
    );

    ced_sync u_maskable_request_sync
    (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .async_in(maskable_request_in),
        .sync_out(maskable_request_sync)
    );

    // ==========================================
    // State
    ced_state_t state_reg;
    logic nmi_prev_reg;
    logic nmi_req_reg;
    logic nmi_active_reg;
    logic if_reg;
    logic busy_reg;
    logic push_req_reg;
    logic inta_req_reg;
    logic dispatch_valid_reg;
    logic [7:0] vec_reg;
    ced_kind_t kind_reg;
    logic dbg_both_reg;
    logic ack_reg;
    logic [31:0] ret_reg;
    logic [31:0] flags_reg;
    logic [10:0] table_reg;
    logic arch_reg;

    logic nmi_edge;
    logic nmi_ok;
    logic maskable_request_ok;
    logic take;
    logic take_nmi;
    logic sel_ack;
    logic sel_both;
    logic [7:0] sel_vec;
    ced_kind_t sel_kind;
    logic [31:0] sel_ret;
    logic [31:0] saved_flags;

    // Level is edge-detected so a held line does not refire after return
    assign nmi_edge = nmi_sync & ~nmi_prev_reg;
    assign nmi_ok = nmi_req_reg & ~nmi_active_reg;
    assign maskable_request_ok = maskable_request_sync & if_reg;

    // ==========================================
    // Event selection
    always_comb
    begin
        take = 1'b0;
        take_nmi = 1'b0;
        sel_ack = 1'b0;
        sel_both = 1'b0;
        sel_vec = `CED_VEC_DIVIDE;
        sel_kind = CED_KIND_FAULT;
        sel_ret = next_addr_in;
        if (exc_valid_in)
        begin
            take = 1'b1;
            sel_vec = cause_vec(exc_cause_in);
            sel_kind = cause_kind(exc_cause_in);
            if (sel_kind != CED_KIND_TRAP)
                sel_ret = current_addr_in;
        end
        else if (swint_valid_in)
        begin
            take = 1'b1;
            sel_vec = swint_vector_in;
            sel_kind = CED_KIND_TRAP;
        end
        else if (breakpoint_in)
        begin
            take = 1'b1;
            sel_vec = `CED_VEC_BREAK;
            sel_kind = CED_KIND_TRAP;
        end
        else if (boundary_in)
        begin
            take = 1'b1;
            if (dbg_trap_in || dbg_fault_in)
            begin
                sel_vec = `CED_VEC_DEBUG;
                sel_kind = dbg_trap_in ? CED_KIND_TRAP : CED_KIND_FAULT;
                sel_both = dbg_trap_in & dbg_fault_in;
            end
            else if (nmi_ok)
            begin
                take_nmi = 1'b1;
                sel_vec = `CED_VEC_NMI;
                sel_kind = CED_KIND_NMI;
            end
            else if (maskable_request_ok)
            begin
                sel_ack = 1'b1;
                sel_kind = CED_KIND_MASKABLE_REQUEST;
            end
            else if (fetch_fault_in)
            begin
                sel_vec = cause_vec(fetch_cause_in);
            end
            else
                take = 1'b0;
        end
        else if (string_window_in && (nmi_ok || maskable_request_ok))
        begin
            // Restart the string instruction where it stopped
            take = 1'b1;
            sel_ret = current_addr_in;
            take_nmi = nmi_ok;
            sel_ack = ~nmi_ok;
            sel_vec = `CED_VEC_NMI;
            sel_kind = nmi_ok ? CED_KIND_NMI : CED_KIND_MASKABLE_REQUEST;
        end
        saved_flags = flags_in;
        saved_flags[`CED_IF_BIT] = if_reg;
    end

    // ==========================================
    // Dispatch sequencer
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_reg <= CED_IDLE;
            busy_reg <= 1'b0;
            push_req_reg <= 1'b0;
            inta_req_reg <= 1'b0;
            dispatch_valid_reg <= 1'b0;
            vec_reg <= `CED_VEC_DIVIDE;
            kind_reg <= CED_KIND_FAULT;
            dbg_both_reg <= 1'b0;
            ack_reg <= 1'b0;
            ret_reg <= 32'h0;
            flags_reg <= 32'h0;
            table_reg <= 11'h0;
            arch_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            dispatch_valid_reg <= 1'b0;
            unique case (state_reg)
                CED_IDLE:
                    if (take)
                    begin
                        vec_reg <= sel_vec;
                        kind_reg <= sel_kind;
                        dbg_both_reg <= sel_both;
                        ack_reg <= sel_ack;
                        ret_reg <= sel_ret;
                        flags_reg <= saved_flags;
                        busy_reg <= 1'b1;
                        push_req_reg <= 1'b1;
                        state_reg <= CED_PUSH;
                    end
                CED_PUSH:
                    if (push_done_in)
                    begin
                        push_req_reg <= 1'b0;
                        inta_req_reg <= ack_reg;
                        state_reg <= ack_reg ? CED_ACK : CED_DISP;
                    end
                CED_ACK:
                    if (inta_valid_in)
                    begin
                        vec_reg <= inta_vector_in;
                        inta_req_reg <= 1'b0;
                        state_reg <= CED_DISP;
                    end
                CED_DISP:
                begin
                    // Offset spans the full 256-entry table in both modes
                    if (real_mode_in)
                        table_reg <= {3'h0, vec_reg} << `CED_REAL_SHIFT;
                    else
                        table_reg <= {3'h0, vec_reg} << `CED_PROT_SHIFT;
                    // Registered so the flag is valid with the dispatch pulse
                    arch_reg <= (vec_reg < `CED_ARCH_VECTORS);
                    dispatch_valid_reg <= 1'b1;
                    busy_reg <= 1'b0;
                    state_reg <= CED_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Interrupt enable flag
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            if_reg <= `CED_RESET_IF;
        else if (clk_en_in)
        begin
            if (state_reg == CED_IDLE && take)
                if_reg <= 1'b0;
            else if (ret_valid_in)
                if_reg <= ret_flags_in[`CED_IF_BIT];
            else if (set_if_in)
                if_reg <= 1'b1;
            else if (clear_if_in)
                if_reg <= 1'b0;
        end
    end

    // ==========================================
    // Non-maskable request tracking
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            nmi_prev_reg <= 1'b0;
            nmi_req_reg <= 1'b0;
            nmi_active_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            nmi_prev_reg <= nmi_sync;
            // A new edge in the taking cycle wins over the clear
            if (nmi_edge)
                nmi_req_reg <= 1'b1;
            else if (state_reg == CED_IDLE && take_nmi)
                nmi_req_reg <= 1'b0;
            if (state_reg == CED_IDLE && take_nmi)
                nmi_active_reg <= 1'b1;
            else if (ret_valid_in)
                nmi_active_reg <= 1'b0;
        end
    end

    // ==========================================
    // Outputs
    assign busy_out = busy_reg;
    assign push_req_out = push_req_reg;
    assign inta_req_out = inta_req_reg;
    assign dispatch_valid_out = dispatch_valid_reg;
    assign vector_out = vec_reg;
    assign kind_out = kind_reg;
    assign dbg_both_out = dbg_both_reg;
    assign arch_vector_out = arch_reg;
    assign return_addr_out = ret_reg;
    assign saved_flags_out = flags_reg;
    assign table_offset_out = table_reg;
    assign int_enable_out = if_reg;
    assign nmi_blocked_out = nmi_active_reg;
    assign nmi_pending_out = nmi_req_reg;

endmodule

// *** hw/ced_params.svh ***
`ifndef CED_PARAMS_SVH
`define CED_PARAMS_SVH

// ==========================================
// Vector space
`define CED_NUM_VECTORS 256
`define CED_ARCH_VECTORS 8'h20
`define CED_VEC_W 8

// ==========================================
// Architectural vectors
`define CED_VEC_DIVIDE 8'h00
`define CED_VEC_DEBUG 8'h01
`define CED_VEC_NMI 8'h02
`define CED_VEC_BREAK 8'h03
`define CED_VEC_OVERFLOW 8'h04
`define CED_VEC_BOUNDS 8'h05
`define CED_VEC_INVALID_OP 8'h06
`define CED_VEC_DEV_NA 8'h07
`define CED_VEC_DOUBLE 8'h08
`define CED_VEC_INVALID_TSS 8'h0A
`define CED_VEC_SEG_ABSENT 8'h0B
`define CED_VEC_STACK 8'h0C
`define CED_VEC_PROTECT 8'h0D
`define CED_VEC_PAGE 8'h0E
`define CED_VEC_FLOAT 8'h10
`define CED_VEC_ALIGN 8'h11

// ==========================================
// Flags and table layout
`define CED_IF_BIT 9
`define CED_RESET_IF 1'b0
`define CED_REAL_SHIFT 2
`define CED_PROT_SHIFT 3
`define CED_TABLE_W 11

`endif

// *** hw/ced_pkg.sv ***
package ced_pkg;

    // ==========================================
    // Dispatch sequencer states
    typedef enum logic [1:0]
    {
        CED_IDLE = 2'h0,
        CED_PUSH = 2'h1,
        CED_ACK = 2'h2,
        CED_DISP = 2'h3
    } ced_state_t;

    // ==========================================
    // How an event is reported
    typedef enum logic [2:0]
    {
        CED_KIND_FAULT = 3'h0,
        CED_KIND_TRAP = 3'h1,
        CED_KIND_ABORT = 3'h2,
        CED_KIND_MASKABLE_REQUEST = 3'h3,
        CED_KIND_NMI = 3'h4
    } ced_kind_t;

    // ==========================================
    // Internal exception causes
    typedef enum logic [3:0]
    {
        CED_C_DIVIDE = 4'h0,
        CED_C_BOUNDS = 4'h1,
        CED_C_INVALID_OP = 4'h2,
        CED_C_DEV_NA = 4'h3,
        CED_C_INVALID_TSS = 4'h4,
        CED_C_SEG_ABSENT = 4'h5,
        CED_C_STACK = 4'h6,
        CED_C_PROTECT = 4'h7,
        CED_C_PAGE = 4'h8,
        CED_C_FLOAT = 4'h9,
        CED_C_ALIGN = 4'hA,
        CED_C_OVERFLOW = 4'hB,
        CED_C_DOUBLE = 4'hC
    } ced_cause_t;

endpackage

// *** hw/ced_sync.sv ***
`timescale 1ns/1ps

module ced_sync
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1_reg;
    logic stage2_reg;

    // ==========================================
    // Two flops; only the second one is read
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule

// *** tb/ced_dispatch_sva.sv ***
`timescale 1ns/1ps

module ced_dispatch_sva
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic exc_valid_in,
    input wire ced_pkg::ced_cause_t exc_cause_in,
    input wire logic swint_valid_in,
    input wire logic [7:0] swint_vector_in,
    input wire logic breakpoint_in,
    input wire logic [31:0] current_addr_in,
    input wire logic [31:0] next_addr_in,
    input wire logic real_mode_in,
    input wire logic push_done_in,
    input wire logic inta_valid_in,
    input wire logic [7:0] inta_vector_in,
    input wire logic busy_out,
    input wire logic push_req_out,
    input wire logic inta_req_out,
    input wire logic dispatch_valid_out,
    input wire logic [7:0] vector_out,
    input wire ced_pkg::ced_kind_t kind_out,
    input wire logic arch_vector_out,
    input wire logic [31:0] return_addr_out,
    input wire logic [10:0] table_offset_out
);
    import ced_pkg::*;

    // ==========================================
    // Dispatch checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    property p_fault;
        exc_valid_in && clk_en_in && !busy_out && exc_cause_in <= CED_C_ALIGN
        |=> kind_out == CED_KIND_FAULT && return_addr_out == $past(current_addr_in);
    endproperty
    a_fault: assert property (p_fault) else $error("fault not reported at faulting address");

    property p_swint;
        swint_valid_in && !exc_valid_in && clk_en_in && !busy_out |=> push_req_out && busy_out
        && vector_out == $past(swint_vector_in) && kind_out == CED_KIND_TRAP && return_addr_out == $past(next_addr_in);
    endproperty
    a_swint: assert property (p_swint) else $error("software trap dispatched wrongly");

    property p_brk;
        breakpoint_in && !exc_valid_in && !swint_valid_in && clk_en_in && !busy_out
        |=> vector_out == 8'h03 && kind_out == CED_KIND_TRAP;
    endproperty
    a_brk: assert property (p_brk) else $error("breakpoint not vector 3 trap");

    property p_ofs;
        dispatch_valid_out |-> table_offset_out == (real_mode_in ? {vector_out, 2'h0} : {vector_out, 3'h0});
    endproperty
    a_ofs: assert property (p_ofs) else $error("table offset wrong");

    property p_arch;
        dispatch_valid_out |-> arch_vector_out == (vector_out < 8'h20);
    endproperty
    a_arch: assert property (p_arch) else $error("architectural flag wrong");

    property p_push;
        push_done_in && push_req_out && kind_out != CED_KIND_MASKABLE_REQUEST |-> ##2 dispatch_valid_out;
    endproperty
    a_push: assert property (p_push) else $error("dispatch late after push");

    property p_inta;
        inta_req_out && inta_valid_in |-> ##2 dispatch_valid_out && vector_out == $past(inta_vector_in, 2);
    endproperty
    a_inta: assert property (p_inta) else $error("acknowledge vector not dispatched");

    property p_noack;
        busy_out && kind_out != CED_KIND_MASKABLE_REQUEST |-> !inta_req_out;
    endproperty
    a_noack: assert property (p_noack) else $error("acknowledge run for internal vector");

    property p_single;
        dispatch_valid_out |-> !busy_out ##1 !dispatch_valid_out;
    endproperty
    a_single: assert property (p_single) else $error("dispatch pulse malformed");
endmodule

bind ced_dispatch ced_dispatch_sva i_ced_dispatch_sva (.clock_in, .rst_in, .clk_en_in, .exc_valid_in, .exc_cause_in,
    .swint_valid_in, .swint_vector_in, .breakpoint_in, .current_addr_in, .next_addr_in, .real_mode_in, .push_done_in,
    .inta_valid_in, .inta_vector_in, .busy_out, .push_req_out, .inta_req_out, .dispatch_valid_out, .vector_out,
    .kind_out, .arch_vector_out, .return_addr_out, .table_offset_out);

// *** tb/ced_pic_model.sv ***
`timescale 1ns/1ps

module ced_pic_model
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic inta_req_in,
    input wire logic [7:0] vec_in,
    input wire logic [3:0] delay_in,
    output logic inta_valid_out,
    output logic [7:0] inta_vector_out
);
    logic [3:0] wait_reg;
    logic done_reg;

    // ==========================================
    // Acknowledge answer, one pulse per request
    // Vector is scrambled outside the pulse so a stale value never looks valid
    assign inta_vector_out = inta_valid_out ? vec_in : ~vec_in;

    always_ff @(posedge clock_in)
    begin
        if (rst_in || !inta_req_in)
        begin
            inta_valid_out <= 1'b0;
            wait_reg <= 4'h0;
            done_reg <= 1'b0;
        end
        else if (inta_valid_out)
        begin
            inta_valid_out <= 1'b0;
            done_reg <= 1'b1;
        end
        else if (!done_reg && wait_reg == delay_in)
            inta_valid_out <= 1'b1;
        else if (!done_reg)
            wait_reg <= wait_reg + 4'h1;
    end
endmodule

// *** tb/cpu_interrupt_exception_dispatch_test.sv ***
`timescale 1ns/1ps

module cpu_interrupt_exception_dispatch_test;
    import ced_pkg::*;

    // ==========================================
    // Signals
    typedef struct packed {logic [4:0] src; logic [3:0] cause; logic [7:0] arg; logic rm; logic [7:0] vec; logic [2:0] kind;}
        ced_row_t;
    localparam logic [31:0] CUR = 32'h0000_1000;
    localparam logic [31:0] NXT = 32'h0000_1004;
    localparam logic [31:0] FLG = 32'h0000_0202;
    logic clock_in = 0, rst_in = 1, clk_en_in = 1, nmi_pin_in = 0, maskable_request_in = 0, boundary_in = 0;
    logic string_window_in = 0, real_mode_in = 0, exc_valid_in = 0, swint_valid_in = 0, breakpoint_in = 0;
    logic dbg_trap_in = 0, dbg_fault_in = 0, fetch_fault_in = 0, push_done_in = 0, ret_valid_in = 0;
    logic set_if_in = 0, clear_if_in = 0, inta_valid_in, busy_out, push_req_out, inta_req_out, dispatch_valid_out;
    logic dbg_both_out, arch_vector_out, int_enable_out, nmi_blocked_out, nmi_pending_out;
    logic [31:0] current_addr_in = CUR, next_addr_in = NXT, flags_in = FLG, ret_flags_in = 0;
    logic [31:0] return_addr_out, saved_flags_out;
    logic [7:0] swint_vector_in = 0, inta_vector_in, vector_out;
    logic [10:0] table_offset_out;
    logic [3:0] pic_delay = 4'h0;
    ced_cause_t exc_cause_in = CED_C_DIVIDE, fetch_cause_in = CED_C_PAGE;
    ced_kind_t kind_out;
    int fail_count = 0, cmp_count = 0, cycles = 0;
    ced_row_t rows [17] = '{'{5'h01, 4'h0, 8'h00, 1'b1, 8'h00, 3'h0}, '{5'h01, 4'h1, 8'h00, 1'b0, 8'h05, 3'h0},
        '{5'h01, 4'h2, 8'h00, 1'b1, 8'h06, 3'h0}, '{5'h01, 4'h3, 8'h00, 1'b0, 8'h07, 3'h0},
        '{5'h01, 4'h4, 8'h00, 1'b1, 8'h0A, 3'h0}, '{5'h01, 4'h5, 8'h00, 1'b0, 8'h0B, 3'h0},
        '{5'h01, 4'h6, 8'h00, 1'b1, 8'h0C, 3'h0}, '{5'h01, 4'h7, 8'h00, 1'b0, 8'h0D, 3'h0},
        '{5'h01, 4'h8, 8'h00, 1'b1, 8'h0E, 3'h0}, '{5'h01, 4'h9, 8'h00, 1'b0, 8'h10, 3'h0},
        '{5'h01, 4'hA, 8'h00, 1'b1, 8'h11, 3'h0}, '{5'h01, 4'hB, 8'h00, 1'b0, 8'h04, 3'h1},
        '{5'h01, 4'hC, 8'h00, 1'b1, 8'h08, 3'h2}, '{5'h01, 4'hF, 8'h00, 1'b0, 8'h08, 3'h2},
        '{5'h02, 4'h0, 8'h40, 1'b1, 8'h40, 3'h1}, '{5'h02, 4'h0, 8'hFF, 1'b0, 8'hFF, 3'h1},
        '{5'h04, 4'h0, 8'h00, 1'b1, 8'h03, 3'h1}};

    ced_dispatch i_ced_dispatch (.clock_in, .rst_in, .clk_en_in, .nmi_pin_in, .maskable_request_in, .boundary_in,
        .string_window_in, .current_addr_in, .next_addr_in, .flags_in, .real_mode_in, .exc_valid_in, .exc_cause_in,
        .swint_valid_in, .swint_vector_in, .breakpoint_in, .dbg_trap_in, .dbg_fault_in, .fetch_fault_in,
        .fetch_cause_in, .push_done_in, .inta_valid_in, .inta_vector_in, .ret_valid_in, .ret_flags_in, .set_if_in,
        .clear_if_in, .busy_out, .push_req_out, .inta_req_out, .dispatch_valid_out, .vector_out, .kind_out,
        .dbg_both_out, .arch_vector_out, .return_addr_out, .saved_flags_out, .table_offset_out, .int_enable_out,
        .nmi_blocked_out, .nmi_pending_out);

    ced_pic_model i_ced_pic_model (.clock_in(clock_in), .rst_in(rst_in), .inta_req_in(inta_req_out),
        .vec_in(8'h41), .delay_in(pic_delay), .inta_valid_out(inta_valid_in), .inta_vector_out(inta_vector_in));

    always #20 clock_in = ~clock_in;

    // ==========================================
    // Helpers
    task automatic end_of_test;
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic fire(input logic [4:0] m);
        {string_window_in, boundary_in, breakpoint_in, swint_valid_in, exc_valid_in} = m;
        @(negedge clock_in);
        {string_window_in, boundary_in, breakpoint_in, swint_valid_in, exc_valid_in} = 5'h00;
    endtask

    task automatic no_take(input logic [4:0] m);
        fire(m);
        check(busy_out, 0);
    endtask

    task automatic pin_wait;
        repeat (3) @(negedge clock_in);
    endtask

    // Push handshake, then the dispatch pulse is checked in its own cycle
    task automatic serve(input logic [7:0] vec, input logic [2:0] kind, input logic [31:0] ret, input logic fl);
        int n;
        n = 0;
        while (push_req_out !== 1'b1 && n < 8)
        begin
            @(negedge clock_in);
            n++;
        end
        push_done_in = 1;
        @(negedge clock_in);
        push_done_in = 0;
        n = 0;
        while (dispatch_valid_out !== 1'b1 && n < 40)
        begin
            @(negedge clock_in);
            n++;
        end
        check(dispatch_valid_out, 1);
        check(vector_out, vec);
        check(kind_out, kind);
        check(return_addr_out, ret);
        check(saved_flags_out, (FLG & ~32'h200) | {22'h0, fl, 9'h0});
        check(table_offset_out, real_mode_in ? {vec, 2'h0} : {vec, 3'h0});
        @(negedge clock_in);
    endtask

    task automatic ret(input logic b);
        ret_flags_in = b ? FLG : FLG & ~32'h200;
        ret_valid_in = 1;
        @(negedge clock_in);
        ret_valid_in = 0;
        check(int_enable_out, b);
    endtask

    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    // ==========================================
    // Sequence
    initial
    begin
        repeat (20) @(negedge clock_in);
        rst_in = 0;
        check({busy_out, push_req_out, int_enable_out, nmi_blocked_out, nmi_pending_out}, 0);
        foreach (rows[i])
        begin
            real_mode_in = rows[i].rm;
            exc_cause_in = ced_cause_t'(rows[i].cause);
            swint_vector_in = rows[i].arg;
            fire(rows[i].src);
            serve(rows[i].vec, rows[i].kind, rows[i].kind == 3'h1 ? NXT : CUR, 1'b0);
        end
        // A second event while busy is ignored
        swint_vector_in = 8'h40;
        fire(5'h02);
        fire(5'h01);
        serve(8'h40, 3'h1, NXT, 1'b0);
        maskable_request_in = 1;
        pin_wait();
        set_if_in = 1;
        @(negedge clock_in);
        {set_if_in, clear_if_in} = 2'b01;
        check(int_enable_out, 1);
        @(negedge clock_in);
        clear_if_in = 0;
        check(int_enable_out, 0);
        no_take(5'h08);
        set_if_in = 1;
        @(negedge clock_in);
        set_if_in = 0;
        pic_delay = 4'h5;
        fire(5'h08);
        check(int_enable_out, 0);
        serve(8'h41, 3'h3, NXT, 1'b1);
        ret(1'b1);
        fire(5'h10);
        serve(8'h41, 3'h3, CUR, 1'b1);
        ret(1'b1);
        nmi_pin_in = 1;
        pin_wait();
        fire(5'h08);
        check(int_enable_out, 0);
        serve(8'h02, 3'h4, NXT, 1'b1);
        check(nmi_blocked_out, 1);
        nmi_pin_in = 0;
        pin_wait();
        nmi_pin_in = 1;
        pin_wait();
        check(nmi_pending_out, 1);
        no_take(5'h08);
        ret(1'b1);
        check(nmi_blocked_out, 0);
        fire(5'h08);
        serve(8'h02, 3'h4, NXT, 1'b1);
        check(nmi_pending_out, 0);
        ret(1'b1);
        pic_delay = 4'h0;
        fire(5'h08);
        serve(8'h41, 3'h3, NXT, 1'b1);
        ret(1'b1);
        nmi_pin_in = 0;
        dbg_trap_in = 1;
        dbg_fault_in = 1;
        fire(5'h08);
        serve(8'h01, 3'h1, NXT, 1'b1);
        check(dbg_both_out, 1);
        ret(1'b1);
        dbg_trap_in = 0;
        dbg_fault_in = 0;
        fetch_fault_in = 1;
        fire(5'h08);
        serve(8'h41, 3'h3, NXT, 1'b1);
        ret(1'b1);
        maskable_request_in = 0;
        pin_wait();
        fire(5'h08);
        serve(8'h0E, 3'h0, NXT, 1'b1);
        // Non-maskable goes ahead of a standing fetch fault; reset then lifts the block
        nmi_pin_in = 1;
        pin_wait();
        fire(5'h08);
        serve(8'h02, 3'h4, NXT, 1'b0);
        check(nmi_blocked_out, 1);
        rst_in = 1;
        @(negedge clock_in);
        rst_in = 0;
        check({busy_out, int_enable_out, nmi_blocked_out, nmi_pending_out}, 0);
        end_of_test();
    end
endmodule
